/* File: verif/air_reader_model.sv */
`timescale 1ns/10ps
`include "nfca_params.svh"

// Remote reader: bit clock runs only inside send and listen
module air_reader_model (
   output logic       air_clk,
   output logic [1:0] rx_sym,
   input  wire logic  tx_bit,
   input  wire logic  tx_en
);
   logic [31:0] heard_q = 32'h0;
   int          n_heard = 0;

   // Idle symbol code while no frame is sent
   initial begin
      air_clk = 1'b0;
      rx_sym  = `NFCA_SYM_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // One 160 ns slot; tag bit sampled at our own rise, before it moves
   task automatic slot(input logic [1:0] s);
      rx_sym = s;
      #80 air_clk = 1'b1;
      if (tx_en === 1'b1) begin
         heard_q[n_heard] = tx_bit;
         n_heard++;
      end
      #80 air_clk = 1'b0;
   endtask

   // Clock the tag while it answers
   task automatic listen(input int n);
      repeat (n) slot(`NFCA_SYM_NONE);
   endtask

   // Reader frame, low bit first, closed by an end symbol
   task automatic send(input logic [15:0] d, input int n);
      for (int i = 0; i < n; i++) slot(d[i] ? `NFCA_SYM_ONE : `NFCA_SYM_ZERO);
      slot(`NFCA_SYM_EOF);
      slot(`NFCA_SYM_NONE);
   endtask
endmodule // air_reader_model

/* File: verif/nfca_frame_dma_engine_tb_top.sv */
`timescale 1ns/10ps
`include "nfca_params.svh"

module nfca_frame_dma_engine_tb_top;
   logic               ref_clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               nv_pin_protect = 1'b0;
   logic [7:0]         reg_addr = 8'h00;
   logic [31:0]        reg_wdata = 32'h0;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic [31:0]        reg_rdata;
   nfca_pkg::mem_req_t mem_req;
   logic [7:0]         mem_rdata;
   logic               air_clk;
   logic [1:0]         rx_sym;
   logic               tx_bit;
   logic               tx_en;
   nfca_pkg::event_t   events;
   logic [7:0]         ram [16];
   logic [31:0]        rv;
   int                 ev_cnt [6];
   int                 n_wr = 0;
   int                 failures = 0;
   int                 n_tests = 0;

   always #5 ref_clk = ~ref_clk;

   nfca_frame_dma_engine u_nfca_frame_dma_engine (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
      .nv_pin_protect(nv_pin_protect), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
      .air_clk(air_clk), .rx_sym(rx_sym), .tx_bit(tx_bit), .tx_en(tx_en), .events(events));

   air_reader_model u_air_reader_model (.air_clk(air_clk), .rx_sym(rx_sym), .tx_bit(tx_bit), .tx_en(tx_en));

   ////////////////////////////////////////////////////////////////////////
   // Engine takes read data at the edge ending its read cycle, so the RAM answers at once
   assign mem_rdata = ram[mem_req.addr[3:0]];

   // Writes land at the edge; counts writes
   always @(posedge ref_clk) begin
      if (mem_req.wr === 1'b1) begin
         ram[mem_req.addr[3:0]] <= mem_req.wdata;
         n_wr++;
      end
   end

   // Event pulses tallied, bit 5 started down to bit 0 fault
   always @(posedge ref_clk) foreach (ev_cnt[i]) if (events[i] === 1'b1) ev_cnt[i]++;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Each access opens on a fresh edge, so no strobe is set twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic reset_dut(input logic pin);
      @(posedge ref_clk);
      rst_n          <= 1'b0;
      nv_pin_protect <= pin;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask

   // Hang guard
   initial begin
      #600000 failures++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      ram[0] = 8'hA5;
      ram[1] = 8'h3C;
      // Pins disabled: enabling and a task must leave it off
      reset_dut(1'b0);
      wr(`NFCA_OFF_CTRL, 32'h1);
      wr(`NFCA_OFF_TASKS, 32'h1);
      rd(`NFCA_OFF_STATE, rv);
      chk(rv, 32'h0);
      chk(ev_cnt[5], 32'h0);
      // A second reset picks up the stored setting again
      reset_dut(1'b1);
      rd(`NFCA_OFF_STATE, rv);
      chk(rv, 32'h8);
      wr(`NFCA_OFF_CTRL, 32'h1);
      rd(`NFCA_OFF_STATE, rv);
      chk(rv, 32'h9);
      // Two bytes with start bit, both tasks at once
      wr(`NFCA_OFF_PTR, 32'h0);
      wr(`NFCA_OFF_LIMIT, 32'h2);
      wr(`NFCA_OFF_TXLEN, 32'h10);
      wr(`NFCA_OFF_TXOPT, 32'h4);
      wr(`NFCA_OFF_TASKS, 32'h3);
      u_air_reader_model.listen(24);
      chk(u_air_reader_model.heard_q[16:0], 32'h794B);
      chk(u_air_reader_model.n_heard, 32'd17);
      chk(ev_cnt[5], 32'h1);
      chk(ev_cnt[4], 32'h1);
      chk(ev_cnt[3], 32'h1);
      chk(ev_cnt[2], 32'h0);
      // Receive 12 bits; pointer moved after started must not count
      wr(`NFCA_OFF_PTR, 32'h4);
      wr(`NFCA_OFF_TASKS, 32'h2);
      wr(`NFCA_OFF_PTR, 32'h9);
      u_air_reader_model.send(16'h035A, 12);
      chk(ram[4], 32'h5A);
      chk(ram[5], 32'h03);
      rd(`NFCA_OFF_RXLEN, rv);
      chk(rv, 32'hC);
      chk(ev_cnt[2], 32'h1);
      chk(ev_cnt[1], 32'h1);
      // Zero limit: nothing stored, overrun flagged
      wr(`NFCA_OFF_LIMIT, 32'h0);
      wr(`NFCA_OFF_TASKS, 32'h2);
      u_air_reader_model.send(16'h00FF, 8);
      rd(`NFCA_OFF_STAT, rv);
      chk(rv[0], 32'h1);
      chk(n_wr, 32'h2);
      chk(ev_cnt[0], 32'h1);
      // Parity on: a wrong parity symbol is flagged as a fault
      wr(`NFCA_OFF_LIMIT, 32'h2);
      wr(`NFCA_OFF_RXOPT, 32'h1);
      wr(`NFCA_OFF_TASKS, 32'h2);
      u_air_reader_model.send(16'h0000, 9);
      rd(`NFCA_OFF_STAT, rv);
      chk(rv, 32'h3);
      chk(ev_cnt[0], 32'h2);
      // Parity after the full byte, partial last byte sent bare
      wr(`NFCA_OFF_PTR, 32'h0);
      wr(`NFCA_OFF_TXLEN, 32'hC);
      wr(`NFCA_OFF_TXOPT, 32'h1);
      wr(`NFCA_OFF_TASKS, 32'h1);
      u_air_reader_model.listen(16);
      chk(u_air_reader_model.heard_q[29:17], 32'h19A5);
      chk(u_air_reader_model.n_heard, 32'd30);
      chk(ev_cnt[3], 32'h2);
      conclude();
   end
endmodule // nfca_frame_dma_engine_tb_top

/* File: verilog/nfca_crc.sv */
`timescale 1ns/10ps
`include "nfca_params.svh"
module nfca_crc (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        clr,
   input  wire logic        en,
   input  wire logic [7:0]  din,
   output logic      [15:0] crc_q
);
   // One byte of the reflected CRC, LSB first as on air
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `NFCA_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Clear wins so every frame starts from the seed
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         crc_q <= `NFCA_CRC_INIT;
      end else if (ce) begin
         if (clr) begin
            crc_q <= `NFCA_CRC_INIT;
         end else if (en) begin
            crc_q <= crc_byte(crc_q, din);
         end
      end
   end
endmodule // nfca_crc

/* File: verilog/nfca_frame_dma_engine.sv */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "nfca_params.svh"

// Operation
// - Reload antenna pin setting on every reset
// - Pins disabled keeps peripheral permanently off
// - RAM read or write, never both; transmit first
// - Begin and done events for RAM transfers
// - Never exceed limit; receive overrun flagged
// - Lengths exclude framing; receive counts CRC
// - Receive pointer only taken on arm task
// - Capture pointer and limit, signal started
// - Lowest address first, LSB first on air
// - Fetch whole bytes plus one partial byte
// - Send eight times bytes plus bits
// - SoF, parity, CRC each independently optional
// - Drop select picks first or last byte
// - Parity after partial first, never partial last
// - Strip and check framing; CRC kept in RAM
// - End symbol gives done event and length
module nfca_frame_dma_engine (
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   input  wire logic           ce,
   input  wire logic           nv_pin_protect,
   input  wire logic [7:0]     reg_addr,
   input  wire logic [31:0]    reg_wdata,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   output logic      [31:0]    reg_rdata,
   output nfca_pkg::mem_req_t  mem_req,
   input  wire logic [7:0]     mem_rdata,
   input  wire logic           air_clk,
   input  wire logic [1:0]     rx_sym,
   output logic                tx_bit,
   output logic                tx_en,
   output nfca_pkg::event_t    events
);
   logic               pin_prot_q;
   logic               enable_q;
   logic [31:0]        ptr_q;
   logic [31:0]        cur_ptr_q;
   logic [8:0]         limit_q;
   logic [8:0]         cur_lim_q;
   logic [8:0]         idx_q;
   logic [8:0]         nbytes_q;
   logic [4:0]         txopt_q;
   logic [4:0]         rxopt_q;
   logic [11:0]        txlen_q;
   logic [11:0]        rxlen_q;
   logic [2:0]         stat_q;
   logic [2:0]         stat_set_q;
   logic [31:0]        rdata_q;
   nfca_pkg::state_t   state_q;
   nfca_pkg::mem_req_t mem_q;
   nfca_pkg::event_t   evt_q;
   logic [8:0]         sh_q;
   logic [3:0]         cnt_q;
   logic [3:0]         rxn_q;
   logic [1:0]         crc_ph_q;
   logic               tx_bit_q;
   logic               tx_en_q;
   logic [7:0]         rxb_q;
   logic               in_frame_q;
   logic               par_err_q;
   logic               ovr_q;
   logic               crc_clr_q;
   logic               crc_en_q;
   logic [7:0]         crc_din_q;
   logic [15:0]        crc_q;
   logic [2:0]         clk_sync_q;
   logic [1:0]         sym_s1_q;
   logic [1:0]         sym_q;
   logic               air_tick;
   logic               tx_task;
   logic               rx_task;
   logic [9:0]         need_w;
   logic [8:0]         fetch_w;
   logic               part_first_w;
   logic               part_last_w;
   logic               bit_w;
   logic [7:0]         full_w;
   logic [7:0]         part_w;
   logic               rx_take;
   logic               rx_eof;
   logic               rx_part;
   logic               wr_go;
   logic [7:0]         wr_byte;
   logic               crc_bad;
   logic [2:0]         stat_clr_w;

   assign reg_rdata = rdata_q;
   assign mem_req   = mem_q;
   assign tx_bit    = tx_bit_q;
   assign tx_en     = tx_en_q;
   assign events    = evt_q;

   // Odd parity over a byte, shared by both directions
   function automatic logic odd_par(input logic [7:0] d);
      return ~^d;
   endfunction

   // Builds {bit count, shifter} for one byte on air
   function automatic logic [12:0] tx_load(input logic [7:0] b, input logic pf, input logic pl,
                                           input logic [2:0] bits, input logic par);
      logic [7:0] d;
      logic [3:0] n;
      logic [8:0] s;
      logic       p;
      d = b;
      n = 4'h8;
      p = par;
      if (pf) begin
         d = b >> (4'h8 - {1'b0, bits});
         n = {1'b0, bits};
      end else if (pl) begin
         n = {1'b0, bits};
         p = 1'b0;
      end
      s = {1'b0, d};
      if (p) begin
         s[n] = odd_par(d);
         n = n + 4'h1;
      end
      return {n, s};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Link sampling: two flops before any use, third for edge history
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         clk_sync_q <= 3'h0;
         sym_s1_q   <= `NFCA_SYM_NONE;
         sym_q      <= `NFCA_SYM_NONE;
      end else if (ce) begin
         clk_sync_q <= {clk_sync_q[1:0], air_clk};
         sym_s1_q   <= rx_sym;
         sym_q      <= sym_s1_q;
      end
   end

   assign air_tick = clk_sync_q[1] & ~clk_sync_q[2];

   // Transmit wins when both tasks share one write
   assign tx_task = reg_wr && (reg_addr == `NFCA_OFF_TASKS) && reg_wdata[`NFCA_TASK_TX];
   assign rx_task = reg_wr && (reg_addr == `NFCA_OFF_TASKS) && reg_wdata[`NFCA_TASK_RX];

   // Bytes to fetch, clipped to the limit
   assign need_w  = {1'b0, txlen_q[11:3]} + {9'h000, |txlen_q[2:0]};
   assign fetch_w = (need_w > {1'b0, limit_q}) ? limit_q : need_w[8:0];
   assign part_first_w = (|txlen_q[2:0]) && txopt_q[`NFCA_OPT_DROP] && (idx_q == 9'h000);
   assign part_last_w  = (|txlen_q[2:0]) && !txopt_q[`NFCA_OPT_DROP] && (idx_q == txlen_q[11:3]);

   // Receive byte assembly, bits arrive LSB first
   assign bit_w   = (sym_q == `NFCA_SYM_ONE);
   assign full_w  = {bit_w, rxb_q[7:1]};
   assign part_w  = rxb_q >> (4'h8 - rxn_q);
   assign rx_take = (state_q == nfca_pkg::ST_RX) && air_tick && (sym_q == `NFCA_SYM_ZERO || bit_w)
                    && (in_frame_q || !rxopt_q[`NFCA_OPT_SOF]);
   assign rx_eof  = (state_q == nfca_pkg::ST_RX) && air_tick && (sym_q == `NFCA_SYM_EOF) && in_frame_q;
   assign rx_part = rx_eof && (rxn_q != 4'h0) && (rxn_q != 4'h8);
   assign wr_go   = (rx_take && (rxn_q == 4'h7)) || rx_part;
   assign wr_byte = rx_part ? part_w : full_w;
   assign crc_bad = rxopt_q[`NFCA_OPT_CRC] && (crc_q != 16'h0000);

   ////////////////////////////////////////////////////////////////////////
   // Pin setting is loaded while reset is held, so it tracks storage
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_prot_q <= nv_pin_protect;
      end
   end

   // Software-written configuration
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         enable_q <= 1'b0;
         ptr_q    <= `NFCA_RST_PTR;
         limit_q  <= `NFCA_RST_LIMIT;
         txopt_q  <= `NFCA_RST_OPT;
         txlen_q  <= `NFCA_RST_LEN;
         rxopt_q  <= `NFCA_RST_OPT;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `NFCA_OFF_CTRL:  enable_q <= reg_wdata[0];
            `NFCA_OFF_PTR:   ptr_q <= reg_wdata;
            `NFCA_OFF_LIMIT: limit_q <= reg_wdata[8:0];
            `NFCA_OFF_TXOPT: txopt_q <= reg_wdata[4:0];
            `NFCA_OFF_TXLEN: txlen_q <= reg_wdata[11:0];
            `NFCA_OFF_RXOPT: rxopt_q <= reg_wdata[4:0];
            default: ;
         endcase
      end
   end

   // Status is write-one-to-clear; a new flag beats the clear
   assign stat_clr_w = (reg_wr && reg_addr == `NFCA_OFF_STAT) ? reg_wdata[2:0] : 3'h0;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         stat_q <= 3'h0;
      end else if (ce) begin
         stat_q <= (stat_q & ~stat_clr_w) | stat_set_q;
      end
   end

   // Read data stand for one cycle only; unmapped reads give zero
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
      end else if (ce) begin
         rdata_q <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               `NFCA_OFF_CTRL:  rdata_q <= {31'h00000000, enable_q};
               `NFCA_OFF_PTR:   rdata_q <= ptr_q;
               `NFCA_OFF_LIMIT: rdata_q <= {23'h000000, limit_q};
               `NFCA_OFF_TXOPT: rdata_q <= {27'h0000000, txopt_q};
               `NFCA_OFF_TXLEN: rdata_q <= {20'h00000, txlen_q};
               `NFCA_OFF_RXOPT: rdata_q <= {27'h0000000, rxopt_q};
               `NFCA_OFF_RXLEN: rdata_q <= {20'h00000, rxlen_q};
               `NFCA_OFF_STAT:  rdata_q <= {29'h00000000, stat_q};
               `NFCA_OFF_STATE: rdata_q <= {28'h0000000, pin_prot_q, state_q};
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer engine: one sequencer owns the RAM port, so no overlap
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q    <= nfca_pkg::ST_OFF;
         mem_q      <= '0;
         evt_q      <= '0;
         cur_ptr_q  <= `NFCA_RST_PTR;
         cur_lim_q  <= `NFCA_RST_LIMIT;
         idx_q      <= 9'h000;
         nbytes_q   <= 9'h000;
         sh_q       <= 9'h000;
         cnt_q      <= 4'h0;
         crc_ph_q   <= 2'h0;
         tx_bit_q   <= 1'b0;
         tx_en_q    <= 1'b0;
         rxb_q      <= 8'h00;
         rxn_q      <= 4'h0;
         in_frame_q <= 1'b0;
         par_err_q  <= 1'b0;
         ovr_q      <= 1'b0;
         rxlen_q    <= `NFCA_RST_LEN;
         stat_set_q <= 3'h0;
         crc_clr_q  <= 1'b1;
         crc_en_q   <= 1'b0;
         crc_din_q  <= 8'h00;
      end else if (ce) begin
         mem_q.rd   <= 1'b0;
         mem_q.wr   <= 1'b0;
         evt_q      <= '0;
         crc_en_q   <= 1'b0;
         crc_clr_q  <= 1'b0;
         stat_set_q <= 3'h0;
         unique case (state_q)
            nfca_pkg::ST_OFF: begin
               if (enable_q && pin_prot_q) begin
                  state_q <= nfca_pkg::ST_IDLE;
               end
            end
            nfca_pkg::ST_IDLE: begin
               crc_clr_q <= 1'b1;
               if (!enable_q) begin
                  state_q <= nfca_pkg::ST_OFF;
               end else if (tx_task) begin
                  cur_ptr_q     <= ptr_q;
                  cur_lim_q     <= limit_q;
                  nbytes_q      <= fetch_w;
                  idx_q         <= 9'h000;
                  crc_ph_q      <= 2'h0;
                  evt_q.started <= 1'b1;
                  sh_q          <= 9'h001;
                  cnt_q         <= txopt_q[`NFCA_OPT_SOF] ? 4'h1 : 4'h0;
                  state_q       <= nfca_pkg::ST_TX_SH;
               end else if (rx_task) begin
                  cur_ptr_q     <= ptr_q;
                  cur_lim_q     <= limit_q;
                  evt_q.started <= 1'b1;
                  idx_q         <= 9'h000;
                  rxn_q         <= 4'h0;
                  in_frame_q    <= 1'b0;
                  par_err_q     <= 1'b0;
                  ovr_q         <= 1'b0;
                  state_q       <= nfca_pkg::ST_RX;
               end
            end
            nfca_pkg::ST_TX_SH: begin
               if (cnt_q != 4'h0) begin
                  if (air_tick) begin
                     tx_en_q  <= 1'b1;
                     tx_bit_q <= sh_q[0];
                     sh_q     <= sh_q >> 1;
                     cnt_q    <= cnt_q - 4'h1;
                  end
               end else if (idx_q != nbytes_q) begin
                  state_q <= nfca_pkg::ST_TX_RD;
               end else if (txopt_q[`NFCA_OPT_CRC] && crc_ph_q != 2'h2) begin
                  {cnt_q, sh_q} <= tx_load(crc_ph_q[0] ? crc_q[15:8] : crc_q[7:0], 1'b0, 1'b0,
                                           txlen_q[2:0], txopt_q[`NFCA_OPT_PAR]);
                  crc_ph_q <= crc_ph_q + 2'h1;
               end else begin
                  state_q <= nfca_pkg::ST_TX_END;
               end
            end
            nfca_pkg::ST_TX_RD: begin
               mem_q.rd   <= 1'b1;
               mem_q.addr <= cur_ptr_q + {23'h000000, idx_q};
               evt_q.transmit_read_begin_event <= (idx_q == 9'h000);
               state_q    <= nfca_pkg::ST_TX_LD;
            end
            nfca_pkg::ST_TX_LD: begin
               {cnt_q, sh_q} <= tx_load(mem_rdata, part_first_w, part_last_w, txlen_q[2:0],
                                        txopt_q[`NFCA_OPT_PAR]);
               crc_en_q  <= 1'b1;
               crc_din_q <= mem_rdata;
               idx_q     <= idx_q + 9'h001;
               evt_q.transmit_read_done_event <= (idx_q + 9'h001 == nbytes_q);
               state_q   <= nfca_pkg::ST_TX_SH;
            end
            nfca_pkg::ST_TX_END: begin
               if (air_tick) begin
                  tx_en_q <= 1'b0;
                  state_q <= nfca_pkg::ST_IDLE;
               end
            end
            nfca_pkg::ST_RX: begin
               // First symbol opens the frame; SoF itself is dropped
               if (air_tick && !in_frame_q && (sym_q == `NFCA_SYM_ZERO || bit_w)) begin
                  in_frame_q <= 1'b1;
                  evt_q.receive_write_begin_event <= 1'b1;
               end
               if (rx_take) begin
                  if (rxn_q == 4'h8) begin
                     par_err_q <= par_err_q | (bit_w != odd_par(rxb_q));
                     rxn_q     <= 4'h0;
                  end else begin
                     rxb_q <= full_w;
                     rxn_q <= (rxn_q != 4'h7) ? rxn_q + 4'h1 :
                              (rxopt_q[`NFCA_OPT_PAR] ? 4'h8 : 4'h0);
                  end
               end
               // Bytes past the limit are dropped and flagged
               if (wr_go) begin
                  if (idx_q < cur_lim_q) begin
                     mem_q.wr    <= 1'b1;
                     mem_q.addr  <= cur_ptr_q + {23'h000000, idx_q};
                     mem_q.wdata <= wr_byte;
                     idx_q       <= idx_q + {8'h00, !rx_part};
                     crc_en_q    <= !rx_part;
                     crc_din_q   <= wr_byte;
                  end else begin
                     ovr_q <= 1'b1;
                  end
               end
               if (rx_eof) begin
                  rxlen_q <= {idx_q, (rxn_q == 4'h8) ? 3'h0 : rxn_q[2:0]};
                  evt_q.receive_write_done_event <= 1'b1;
                  stat_set_q <= {crc_bad, par_err_q, ovr_q | (rx_part && idx_q >= cur_lim_q)};
                  evt_q.receive_fault_event <= crc_bad | par_err_q | ovr_q
                                               | (rx_part && idx_q >= cur_lim_q);
                  in_frame_q <= 1'b0;
                  state_q    <= nfca_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   nfca_crc u_crc (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .clr     (crc_clr_q),
      .en      (crc_en_q),
      .din     (crc_din_q),
      .crc_q   (crc_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks beside the logic
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_one_dir;
      !(mem_q.rd && mem_q.wr);
   endproperty
   a_one_dir: assert property (p_one_dir) else $error("RAM read and write together");

   property p_pin_off;
      !pin_prot_q |-> state_q == nfca_pkg::ST_OFF;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("Left off state with pins disabled");

   property p_pin_load;
      $rose(rst_n) |-> pin_prot_q == $past(nv_pin_protect);
   endproperty
   a_pin_load: assert property (p_pin_load) else $error("Pin setting not reloaded");

   property p_limit;
      (mem_q.rd || mem_q.wr) |-> (mem_q.addr - cur_ptr_q) < {23'h000000, cur_lim_q};
   endproperty
   a_limit: assert property (p_limit) else $error("Access beyond length limit");

   property p_tx_begin;
      evt_q.transmit_read_begin_event |-> mem_q.rd && mem_q.addr == cur_ptr_q;
   endproperty
   a_tx_begin: assert property (p_tx_begin) else $error("Begin event without first read");

   property p_started;
      evt_q.started |-> cur_ptr_q == $past(ptr_q) && cur_lim_q == $past(limit_q);
   endproperty
   a_started: assert property (p_started) else $error("Pointer not captured at start");

   property p_rx_ptr;
      (state_q == nfca_pkg::ST_RX && $past(state_q) == nfca_pkg::ST_RX && ce) |-> $stable(cur_ptr_q);
   endproperty
   a_rx_ptr: assert property (p_rx_ptr) else $error("Receive pointer moved mid frame");

   property p_rx_end;
      evt_q.receive_write_done_event |-> $past(sym_q) == `NFCA_SYM_EOF ##1 state_q == nfca_pkg::ST_IDLE;
   endproperty
   a_rx_end: assert property (p_rx_end) else $error("Receive done without end symbol");

   property p_rd_order;
      mem_q.rd |-> mem_q.addr == cur_ptr_q + {23'h000000, idx_q} ##2 idx_q == $past(idx_q, 2) + 9'h001;
   endproperty
   a_rd_order: assert property (p_rd_order) else $error("Reads not in rising order");

   c_tx_done: cover property (evt_q.transmit_read_done_event);
   c_rx_done: cover property (evt_q.receive_write_done_event);
   c_rx_fault: cover property (evt_q.receive_fault_event);
endmodule // nfca_frame_dma_engine

/* File: verilog/nfca_params.svh */
`ifndef NFCA_PARAMS_SVH
`define NFCA_PARAMS_SVH
// Register byte offsets
`define NFCA_OFF_CTRL  8'h00
`define NFCA_OFF_TASKS 8'h04
`define NFCA_OFF_PTR   8'h08
`define NFCA_OFF_LIMIT 8'h0C
`define NFCA_OFF_TXOPT 8'h10
`define NFCA_OFF_TXLEN 8'h14
`define NFCA_OFF_RXOPT 8'h18
`define NFCA_OFF_RXLEN 8'h1C
`define NFCA_OFF_STAT  8'h20
`define NFCA_OFF_STATE 8'h24
// Frame option bits
`define NFCA_OPT_PAR  0
`define NFCA_OPT_DROP 1
`define NFCA_OPT_SOF  2
`define NFCA_OPT_CRC  4
// Task bits
`define NFCA_TASK_TX 0
`define NFCA_TASK_RX 1
// Status bits
`define NFCA_ST_OVR 0
`define NFCA_ST_PAR 1
`define NFCA_ST_CRC 2
// Demodulated air symbols
`define NFCA_SYM_NONE 2'h0
`define NFCA_SYM_ZERO 2'h1
`define NFCA_SYM_ONE  2'h2
`define NFCA_SYM_EOF  2'h3
// Frame check sequence
`define NFCA_CRC_INIT 16'h6363
`define NFCA_CRC_POLY 16'h8408
// Reset values
`define NFCA_RST_PTR   32'h00000000
`define NFCA_RST_LIMIT 9'h000
`define NFCA_RST_OPT   5'h00
`define NFCA_RST_LEN   12'h000
`endif

/* File: verilog/nfca_pkg.sv */
package nfca_pkg;
   typedef enum logic [2:0] {ST_OFF, ST_IDLE, ST_TX_RD, ST_TX_LD, ST_TX_SH, ST_TX_END, ST_RX} state_t;
   typedef struct packed {
      logic started;
      logic transmit_read_begin_event;
      logic transmit_read_done_event;
      logic receive_write_begin_event;
      logic receive_write_done_event;
      logic receive_fault_event;
   } event_t;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;
endpackage
